// file: core/rel_top.sv
// Purpose: ring event latch with mask, clear and interrupt on Wishbone
// Assumes: event inputs are synchronous one-cycle or level indications
// Notes:   ack comes one cycle after a request is seen
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "rel_regs.svh"

// What this block does
// RL1 - set rise bit on ring op 0 to 1
// RL2 - set fall bit on ring op 1 to 0
// RL3 - beacon sets bit, blocks restricted and synchronous
// RL4 - claim sets bit, blocks restricted requests
// RL5 - other MAC frame sets bit, blocks restricted
// RL6 - phy invalid indication sets its bit
// RL7 - phy invalid forces receiver into listen
// RL8 - own frame with A set flags duplicate
// RL9 - latch bits reach the interrupt condition only when masked in; the irq line uses the irq enable
// RL10 - bits stay until cleared; bit 7 zero
module rel_top
   import rel_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   // ring and receiver indications
   input  wire logic        ring_op_i,
   input  wire logic        rx_frame_start_i,
   input  wire logic        rx_frame_end_i,
   input  wire logic        rx_valid_i,
   input  wire logic        rx_beacon_i,
   input  wire logic        rx_claim_i,
   input  wire logic        rx_mac_frame_i,
   input  wire logic        rx_individual_i,
   input  wire logic        rx_my_addr_i,
   input  wire logic        rx_a_ind_i,
   input  wire logic        phy_invalid_i,
   // transmit request gating and receiver listen state
   output var  logic        restricted_ok_o,
   output var  logic        synchronous_ok_o,
   output var  logic        receiver_listen_state,
   // interrupt condition and line
   output var  logic [6:0]  int_cond_o,
   output var  logic        irq_o
);
   localparam int NE = `REL_NUM_EVENTS;

   typedef struct packed
   {
      logic [31:0]   dat;
      logic          ack;
      logic          ring_op_d1;
      logic [NE-1:0] mask;
      logic [NE-1:0] irq_en;
      rel_rx_state_t rx;
      logic          restr_ok;
      logic          sync_ok;
      logic          listen;
      logic [NE-1:0] cond;
      logic          irq;
   } rel_st_t;

   rel_st_t st_q;
   rel_st_t st_d;

   // ======================================================================
   // bus decode
   logic          req;
   logic          wr_lo;
   logic [NE-1:0] ev_set;
   logic [NE-1:0] ev_clr;
   logic [NE-1:0] latch;
   logic          valid_own;

   assign req   = wb_cyc_i && wb_stb_i && !st_q.ack;
   assign wr_lo = req && wb_we_i && wb_sel_i[0];

   // only a completed good frame may latch frame events
   assign valid_own = rx_frame_end_i && rx_valid_i;

   always_comb
   begin
      ev_set = '0;
      ev_set[`REL_B_OP_RISE]   = ring_op_i && !st_q.ring_op_d1; // RL1
      ev_set[`REL_B_OP_FALL]   = !ring_op_i && st_q.ring_op_d1; // RL2
      ev_set[`REL_B_BEACON]    = valid_own && rx_beacon_i; // RL3
      ev_set[`REL_B_CLAIM]     = valid_own && rx_claim_i; // RL4
      ev_set[`REL_B_OTHER_MAC] = valid_own && rx_mac_frame_i
                                 && !rx_beacon_i && !rx_claim_i; // RL5
      ev_set[`REL_B_PHY_INV]   = phy_invalid_i; // RL6
      ev_set[`REL_B_DUP_ADDR]  = valid_own && rx_individual_i
                                 && rx_my_addr_i && rx_a_ind_i; // RL8
   end

   // write-one-to-clear on latch or clear register; writes never set
   always_comb
   begin
      ev_clr = '0;
      if (wr_lo && (wb_adr_i == `REL_ADDR_LATCH0
                    || wb_adr_i == `REL_ADDR_CLEAR))
         ev_clr = wb_dat_i[NE-1:0]; // RL10
   end

   genvar gi;
   generate
      for (gi = 0; gi < NE; gi++)
      begin : g_ev
         rel_sticky u_bit
         (
            .clk_sys (clk_sys),
            .reset_n (reset_n),
            .set_i   (ev_set[gi]),
            .clr_i   (ev_clr[gi]),
            .bit_q   (latch[gi])
         );
      end
   endgenerate

   // ======================================================================
   // next state
   always_comb
   begin
      st_d            = st_q;
      st_d.ack        = req;
      st_d.ring_op_d1 = ring_op_i;
      if (req && !wb_we_i)
      begin
         if (wb_adr_i == `REL_ADDR_LATCH0
             || wb_adr_i == `REL_ADDR_STATUS)
            st_d.dat = {24'h000000, 1'b0, latch}; // RL10
         else if (wb_adr_i == `REL_ADDR_MASK0)
            st_d.dat = {25'h0000000, st_q.mask};
         else if (wb_adr_i == `REL_ADDR_IRQ_EN)
            st_d.dat = {25'h0000000, st_q.irq_en};
         else
            st_d.dat = 32'h00000000;
      end
      else if (req)
         st_d.dat = 32'h00000000;
      if (wr_lo)
      begin
         if (wb_adr_i == `REL_ADDR_MASK0)
            st_d.mask = wb_dat_i[NE-1:0];
         else if (wb_adr_i == `REL_ADDR_IRQ_EN)
            st_d.irq_en = wb_dat_i[NE-1:0];
      end
      // receiver mode tracker
      case (st_q.rx)
         REL_RX_LISTEN:
            if (rx_frame_start_i)
               st_d.rx = REL_RX_FRAME;
         REL_RX_ACTIVE:
            if (rx_frame_start_i)
               st_d.rx = REL_RX_FRAME;
         REL_RX_FRAME:
            if (rx_frame_end_i)
               st_d.rx = REL_RX_ACTIVE;
         default:
            st_d.rx = REL_RX_LISTEN;
      endcase
      if (phy_invalid_i)
         st_d.rx = REL_RX_LISTEN; // RL7
      st_d.listen   = (st_d.rx == REL_RX_LISTEN);
      // gating follows the current latch plus this cycle's new events, not its clears
      st_d.restr_ok = !((latch[`REL_B_BEACON] || ev_set[`REL_B_BEACON])
                        || (latch[`REL_B_CLAIM] || ev_set[`REL_B_CLAIM])
                        || (latch[`REL_B_OTHER_MAC]
                            || ev_set[`REL_B_OTHER_MAC])); // RL3
      st_d.sync_ok  = !(latch[`REL_B_BEACON]
                        || ev_set[`REL_B_BEACON]); // RL3
      st_d.cond     = latch & st_q.mask; // RL9
      st_d.irq      = |(latch & st_q.irq_en);
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q            <= '0;
         st_q.mask       <= `REL_RST_MASK;
         st_q.irq_en     <= `REL_RST_IRQ_EN;
         st_q.rx         <= REL_RX_LISTEN;
         st_q.restr_ok   <= 1'b1;
         st_q.sync_ok    <= 1'b1;
         st_q.listen     <= 1'b1;
      end
      else
         st_q <= st_d;
   end

   assign wb_dat_o              = st_q.dat;
   assign wb_ack_o              = st_q.ack;
   assign restricted_ok_o       = st_q.restr_ok;
   assign synchronous_ok_o      = st_q.sync_ok;
   assign receiver_listen_state = st_q.listen;
   assign int_cond_o            = st_q.cond;
   assign irq_o                 = st_q.irq;

   // ======================================================================
   // checks
   property p_rise;
      @(posedge clk_sys) disable iff (!reset_n)
      $rose(ring_op_i) |=> latch[`REL_B_OP_RISE];
   endproperty
   a_rise: assert property (p_rise) // RL1
      else $error("rise not latched");

   property p_fall;
      @(posedge clk_sys) disable iff (!reset_n)
      $fell(ring_op_i) |=> latch[`REL_B_OP_FALL];
   endproperty
   a_fall: assert property (p_fall) // RL2
      else $error("fall not latched");

   property p_beacon;
      @(posedge clk_sys) disable iff (!reset_n)
      latch[`REL_B_BEACON] |=> !synchronous_ok_o && !restricted_ok_o;
   endproperty
   a_beacon: assert property (p_beacon) // RL3
      else $error("service allowed under beacon");

   property p_claim;
      @(posedge clk_sys) disable iff (!reset_n)
      latch[`REL_B_CLAIM] |=> !restricted_ok_o;
   endproperty
   a_claim: assert property (p_claim) // RL4
      else $error("restricted allowed under claim");

   property p_other;
      @(posedge clk_sys) disable iff (!reset_n)
      latch[`REL_B_OTHER_MAC] |=> !restricted_ok_o;
   endproperty
   a_other: assert property (p_other) // RL5
      else $error("restricted allowed under mac frame");

   property p_phy_inv;
      @(posedge clk_sys) disable iff (!reset_n)
      phy_invalid_i |=> latch[`REL_B_PHY_INV];
   endproperty
   a_phy_inv: assert property (p_phy_inv) // RL6
      else $error("phy invalid not latched");

   property p_listen;
      @(posedge clk_sys) disable iff (!reset_n)
      phy_invalid_i |=> receiver_listen_state;
   endproperty
   a_listen: assert property (p_listen) // RL7
      else $error("receiver not listening");

   property p_dup;
      @(posedge clk_sys) disable iff (!reset_n)
      (valid_own && rx_individual_i && rx_my_addr_i && rx_a_ind_i)
         |=> latch[`REL_B_DUP_ADDR];
   endproperty
   a_dup: assert property (p_dup) // RL8
      else $error("duplicate address not latched");

   property p_cond;
      @(posedge clk_sys) disable iff (!reset_n)
      ##1 int_cond_o == ($past(latch) & $past(st_q.mask));
   endproperty
   a_cond: assert property (p_cond) // RL9
      else $error("interrupt condition not masked");

   property p_nowrset;
      @(posedge clk_sys) disable iff (!reset_n)
      (ev_set == '0 && !latch[0]) |=> !latch[0];
   endproperty
   a_nowrset: assert property (p_nowrset) // RL10
      else $error("bit set without event");

   // writes and idle cycles never raise any latch bit on their own
   property p_no_stray_set;
      @(posedge clk_sys) disable iff (!reset_n)
      (ev_set == '0) |=> ((latch & ~$past(latch)) == '0);
   endproperty
   a_no_stray_set: assert property (p_no_stray_set) // RL10
      else $error("latch bit set without event");

   property p_high_zero;
      @(posedge clk_sys) disable iff (!reset_n)
      wb_ack_o |-> (wb_dat_o[31:NE] == '0);
   endproperty
   a_high_zero: assert property (p_high_zero) // RL10
      else $error("unused read bits not zero");

   // gating must come back once the blocking bits are gone
   property p_sync_back;
      @(posedge clk_sys) disable iff (!reset_n)
      (!latch[`REL_B_BEACON] && !ev_set[`REL_B_BEACON])
         |=> synchronous_ok_o;
   endproperty
   a_sync_back: assert property (p_sync_back) // RL3
      else $error("synchronous service blocked without beacon");

   property p_restr_back;
      @(posedge clk_sys) disable iff (!reset_n)
      (latch[`REL_B_OTHER_MAC:`REL_B_BEACON] == 3'h0
       && ev_set[`REL_B_OTHER_MAC:`REL_B_BEACON] == 3'h0)
         |=> restricted_ok_o;
   endproperty
   a_restr_back: assert property (p_restr_back) // RL4
      else $error("restricted service blocked without cause");

   // a clear with no competing event empties the bits it names
   property p_clear;
      @(posedge clk_sys) disable iff (!reset_n)
      (ev_clr != '0 && ev_set == '0) |=> ((latch & $past(ev_clr)) == '0);
   endproperty
   a_clear: assert property (p_clear) // RL10
      else $error("latch bit survived a clear");

   property p_irq_quiet;
      @(posedge clk_sys) disable iff (!reset_n)
      (st_q.irq_en == '0) |=> !irq_o;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet)
      else $error("interrupt raised with nothing enabled");

   property p_mask_wr;
      @(posedge clk_sys) disable iff (!reset_n)
      (wr_lo && wb_adr_i == `REL_ADDR_MASK0)
         |=> (st_q.mask == $past(wb_dat_i[NE-1:0]));
   endproperty
   a_mask_wr: assert property (p_mask_wr) // RL9
      else $error("mask write lost");

   c_rise: cover property (@(posedge clk_sys) $rose(ring_op_i));
   c_irq:  cover property (@(posedge clk_sys) $rose(irq_o));
   c_clr:  cover property (@(posedge clk_sys) |ev_clr && |latch);
   c_beacon: cover property (@(posedge clk_sys) ev_set[`REL_B_BEACON]);
   c_listen: cover property (@(posedge clk_sys)
      phy_invalid_i && !receiver_listen_state);
endmodule
`default_nettype wire

// file: core/rel_regs.svh
// Purpose: offsets, field positions, reset values for the ring event latch
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes:   one aligned word per register
`ifndef REL_REGS_SVH
`define REL_REGS_SVH

// ==========================================================================
// register byte addresses (register index times four)
`define REL_IDX_LATCH0    8'h10
`define REL_IDX_MASK0     8'h11
`define REL_ADDR_LATCH0   8'h40
`define REL_ADDR_MASK0    8'h44
`define REL_ADDR_CLEAR    8'h80
`define REL_ADDR_IRQ_EN   8'h84
`define REL_ADDR_STATUS   8'h88

// ==========================================================================
// field positions
`define REL_B_OP_RISE     0
`define REL_B_OP_FALL     1
`define REL_B_BEACON      2
`define REL_B_CLAIM       3
`define REL_B_OTHER_MAC   4
`define REL_B_PHY_INV     5
`define REL_B_DUP_ADDR    6
`define REL_NUM_EVENTS    7

// ==========================================================================
// reset values
`define REL_RST_LATCH     7'h00
`define REL_RST_MASK      7'h00
`define REL_RST_IRQ_EN    7'h00

`endif

// file: core/rel_pkg.sv
// Purpose: types of the ring event latch
// Assumes: nothing
// Notes:   offsets live in rel_regs.svh
package rel_pkg;
   typedef enum logic [1:0] {
      REL_RX_LISTEN,
      REL_RX_ACTIVE,
      REL_RX_FRAME
   } rel_rx_state_t;
endpackage

// file: core/rel_sticky.sv
// Purpose: one sticky event bit, set beats clear
// Assumes: single clock, async active-low reset
// Notes:   used once per latch event
`timescale 1ns/1ps
`default_nettype none
module rel_sticky
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic reset_n,
   // control
   input  wire logic set_i,
   input  wire logic clr_i,
   // state
   output var  logic bit_q
);
   typedef struct packed
   {
      logic b;
   } rel_sticky_st_t;

   rel_sticky_st_t st_q;
   rel_sticky_st_t st_d;

   always_comb
   begin
      st_d = st_q;
      if (set_i)
         st_d.b = 1'b1;
      else if (clr_i)
         st_d.b = 1'b0;
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign bit_q = st_q.b;

   property p_set_wins;
      @(posedge clk_sys) disable iff (!reset_n)
      set_i |=> bit_q;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("sticky bit lost a set");

   property p_hold;
      @(posedge clk_sys) disable iff (!reset_n)
      (bit_q && !clr_i) |=> bit_q;
   endproperty
   a_hold: assert property (p_hold)
      else $error("sticky bit dropped without clear");
endmodule
`default_nettype wire

// file: tb/rel_host_model.sv
// Purpose: host that reads and clears the ring event latch
// Assumes: classic Wishbone, one request at a time
// Notes:   tb calls rd and wr
`timescale 1ns/1ps
`default_nettype none
module rel_host_model
(
   // clock
   input  wire logic        clk_sys,
   // wishbone master
   output var  logic        cyc,
   output var  logic        stb,
   output var  logic        we,
   output var  logic [7:0]  adr,
   output var  logic [3:0]  sel,
   output var  logic [31:0] dat_w,
   // slave answer
   input  wire logic [31:0] dat_r,
   input  wire logic        ack
);
   initial
   begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat_w = 32'h0;
   end

   // ====================================================================
   // single cycle, held until ack is sampled
   task automatic access(input logic w, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      dat_w <= d;
      do
         @(posedge clk_sys);
      while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      // released lines stop showing the old value
      adr <= ~a;
      dat_w <= ~d;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      access(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      access(1'b0, a, 32'h0, q);
   endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench for the ring event latch
// Assumes: ack one cycle after a request, events latch next edge
// Notes:   frame events come from a table
`timescale 1ns/1ps
`default_nettype none
`include "rel_regs.svh"
module tb
   import rel_pkg::*;
;
   logic        clk_sys, reset_n, cyc, stb, we, ack;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat_w, dat_r, rd_q;
   logic        ring_op, f_start, f_end, phy_inv;
   logic        r_ok, s_ok, listen, irq;
   logic [6:0]  qual, e, int_cond;
   int          num_errors = 0;
   int          n_tests = 0;
   int          cycles = 0;
   // valid,beacon,claim,mac,indiv,my_addr,a_ind then expected latch
   logic [13:0] tab [6] = '{{7'b1101000, 7'h04}, {7'b1011000, 7'h08},
      {7'b1001000, 7'h10}, {7'b1000111, 7'h40}, {7'b1000110, 7'h00},
      {7'b0101000, 7'h00}};

   rel_host_model host (.clk_sys(clk_sys), .cyc(cyc), .stb(stb),
      .we(we), .adr(adr), .sel(sel), .dat_w(dat_w), .dat_r(dat_r),
      .ack(ack));

   rel_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .ring_op_i(ring_op), .rx_frame_start_i(f_start),
      .rx_frame_end_i(f_end), .rx_valid_i(qual[6]),
      .rx_beacon_i(qual[5]), .rx_claim_i(qual[4]),
      .rx_mac_frame_i(qual[3]), .rx_individual_i(qual[2]),
      .rx_my_addr_i(qual[1]), .rx_a_ind_i(qual[0]),
      .phy_invalid_i(phy_inv), .restricted_ok_o(r_ok),
      .synchronous_ok_o(s_ok), .receiver_listen_state(listen),
      .int_cond_o(int_cond), .irq_o(irq));

   // ====================================================================
   // clock and hang guard
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         num_errors++;
         finish_test();
      end
   end

   // ====================================================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] g);
      n_tests++;
      if (g !== x)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
      host.rd(a, rd_q);
      chk($sformatf("reg %h", a), x, rd_q);
   endtask

   task automatic frame(input logic [6:0] q);
      @(posedge clk_sys);
      f_start <= 1'b1;
      @(posedge clk_sys);
      f_start <= 1'b0;
      f_end <= 1'b1;
      qual <= q;
      @(posedge clk_sys);
      f_end <= 1'b0;
      qual <= 7'h00;
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ====================================================================
   // main sequence
   initial
   begin
      reset_n = 1'b0;
      ring_op = 1'b0;
      f_start = 1'b0;
      f_end = 1'b0;
      phy_inv = 1'b0;
      qual = 7'h00;
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      rdchk(`REL_ADDR_LATCH0, 32'h0);
      chk("listen", 32'h1, 32'(listen));
      ring_op <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rdchk(`REL_ADDR_LATCH0, 32'h01);
      ring_op <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rdchk(`REL_ADDR_LATCH0, 32'h03);
      host.wr(`REL_ADDR_CLEAR, 32'h03);
      rdchk(`REL_ADDR_LATCH0, 32'h0);
      for (int i = 0; i < 6; i++)
      begin
         frame(tab[i][13:7]);
         e = tab[i][6:0];
         rdchk(`REL_ADDR_LATCH0, 32'(e));
         chk("restricted_ok", 32'(!(e[2] | e[3] | e[4])), 32'(r_ok));
         chk("synchronous_ok", 32'(!e[2]), 32'(s_ok));
         host.wr(`REL_ADDR_CLEAR, 32'h7f);
      end
      // a frame in progress must not keep the receiver out of listen
      f_start <= 1'b1;
      @(posedge clk_sys);
      f_start <= 1'b0;
      phy_inv <= 1'b1;
      @(posedge clk_sys);
      phy_inv <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("listen", 32'h1, 32'(listen));
      rdchk(`REL_ADDR_LATCH0, 32'h20);
      host.wr(`REL_ADDR_LATCH0, 32'hffffff5f);
      rdchk(`REL_ADDR_LATCH0, 32'h20);
      rdchk(`REL_ADDR_STATUS, 32'h20);
      host.wr(`REL_ADDR_MASK0, 32'h20);
      rdchk(`REL_ADDR_MASK0, 32'h20);
      chk("int_cond", 32'h20, 32'(int_cond));
      host.wr(`REL_ADDR_MASK0, 32'h5f);
      rdchk(`REL_ADDR_MASK0, 32'h5f);
      chk("int_cond", 32'h0, 32'(int_cond));
      chk("irq", 32'h0, 32'(irq));
      host.wr(`REL_ADDR_IRQ_EN, 32'h20);
      rdchk(`REL_ADDR_IRQ_EN, 32'h20);
      chk("irq", 32'h1, 32'(irq));
      host.wr(`REL_ADDR_CLEAR, 32'h20);
      rdchk(`REL_ADDR_LATCH0, 32'h0);
      chk("irq", 32'h0, 32'(irq));
      rdchk(`REL_ADDR_CLEAR, 32'h0);
      rdchk(8'hf0, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
